// >>> core/dlc_pkg.sv
package dlc_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_ALPHA   = 12'h004;
  localparam logic [11:0] OFF_SPLIT   = 12'h008;
  localparam logic [11:0] OFF_HTIM    = 12'h00c;
  localparam logic [11:0] OFF_VTIM    = 12'h010;
  localparam logic [11:0] OFF_START_L = 12'h014;
  localparam logic [11:0] OFF_START_R = 12'h018;
  localparam logic [11:0] OFF_CUR0    = 12'h01c;
  localparam logic [11:0] OFF_CUR1    = 12'h020;
  localparam logic [11:0] OFF_FLIP    = 12'h024;
  localparam logic [11:0] OFF_STATUS  = 12'h028;
  localparam logic [1:0]  PAL_PAGE    = 2'h1;
  // Control field positions
  localparam int CTRL_DBUF  = 0;
  localparam int CTRL_EXT   = 1;
  localparam int CTRL_TRANS = 2;
  localparam int CTRL_DIRL  = 3;
  localparam int CTRL_DIRR  = 4;
  localparam int CTRL_INTL  = 5;
  localparam int CTRL_LAYEN = 6;
  localparam int CTRL_BLEND = 9;
  localparam int CTRL_CUREN = 12;
  // Palette entry layout
  localparam int PAL_ALPHA  = 18;
  // Reset values
  localparam logic [13:0] CTRL_RST  = 14'h0000;
  localparam logic [7:0]  ALPHA_RST = 8'h80;
  localparam logic [10:0] SPLIT_RST = 11'h7ff;
  localparam logic [10:0] HACT_RST  = 11'h280;
  localparam logic [10:0] HTOT_RST  = 11'h320;
  localparam logic [10:0] VACT_RST  = 11'h1e0;
  localparam logic [10:0] VTOT_RST  = 11'h20d;
  // Resolution limits, sync shape and cursor size
  localparam logic [10:0] H_MIN    = 11'h140;
  localparam logic [10:0] H_MAX    = 11'h400;
  localparam logic [10:0] V_MIN    = 11'h0ea;
  localparam logic [10:0] V_MAX    = 11'h300;
  localparam logic [10:0] HS_FRONT = 11'h010;
  localparam logic [10:0] HS_WIDTH = 11'h060;
  localparam logic [10:0] VS_FRONT = 11'h003;
  localparam logic [10:0] VS_WIDTH = 11'h002;
  localparam logic [10:0] CUR_SIZE = 11'h040;

  typedef struct packed {
    logic [10:0] hcnt;
    logic [10:0] vcnt;
    logic        hs_n;
    logic        vs_n;
    logic        vblank;
    logic        active;
    logic        fstart;
    logic        ext_hs_d;
    logic        ext_vs_d;
  } dlc_tg_t;

  typedef struct packed {
    logic [13:0]        ctrl;
    logic [7:0]         alpha;
    logic [7:0]         alpha_frame;
    logic [10:0]        split;
    logic [10:0]        h_act;
    logic [10:0]        h_tot;
    logic [10:0]        v_act;
    logic [10:0]        v_tot;
    logic [23:0]        start_l;
    logic [23:0]        start_r;
    logic [1:0][21:0]   cur;
    logic               flip_pend;
    logic               bank;
    logic               field;
    logic [255:0][18:0] pal;
    logic [23:0]        rgb;
    logic [23:0]        fetch_base;
    logic               gv;
    logic               hs_d;
    logic               vs_d;
    logic [31:0]        prdata;
    logic               slverr;
    logic               hs_m;
    logic               hs_s;
    logic               vs_m;
    logic               vs_s;
    logic               fp_m;
    logic               fp_s;
  } dlc_st_t;
endpackage

// >>> core/dlc_timing.sv
`timescale 1ns/100ps
module dlc_timing (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [10:0] h_act,
  input  wire logic [10:0] h_tot,
  input  wire logic [10:0] v_act,
  input  wire logic [10:0] v_tot,
  input  wire logic        ext_mode,
  input  wire logic        ext_hs_n,
  input  wire logic        ext_vs_n,
  output logic      [10:0] x,
  output logic      [10:0] y,
  output logic             active,
  output logic             hs_n,
  output logic             vs_n,
  output logic             vblank,
  output logic             fstart
);
  dlc_pkg::dlc_tg_t r_reg;
  dlc_pkg::dlc_tg_t r_next;
  logic [10:0] hact;
  logic [10:0] vact;
  logic        hs_fall;
  logic        vs_fall;
  logic        line_end;

  // Counters free-run or lock to the outside sync edges
  always_comb begin
    r_next = r_reg;
    hact = (h_act < dlc_pkg::H_MIN) ? dlc_pkg::H_MIN :
           (h_act > dlc_pkg::H_MAX) ? dlc_pkg::H_MAX : h_act;
    vact = (v_act < dlc_pkg::V_MIN) ? dlc_pkg::V_MIN :
           (v_act > dlc_pkg::V_MAX) ? dlc_pkg::V_MAX : v_act;
    r_next.ext_hs_d = ext_hs_n;
    r_next.ext_vs_d = ext_vs_n;
    hs_fall = ext_mode && r_reg.ext_hs_d && !ext_hs_n;
    vs_fall = ext_mode && r_reg.ext_vs_d && !ext_vs_n;
    line_end = hs_fall || (!ext_mode && r_reg.hcnt >= h_tot - 11'h001);
    r_next.fstart = 1'b0;
    if (line_end) begin
      r_next.hcnt = 11'h000;
      if (!ext_mode && r_reg.vcnt >= v_tot - 11'h001) begin
        r_next.vcnt = 11'h000;
        r_next.fstart = 1'b1;
      end else begin
        r_next.vcnt = r_reg.vcnt + 11'h001;
      end
    end else begin
      r_next.hcnt = r_reg.hcnt + 11'h001;
    end
    if (vs_fall) begin
      r_next.vcnt = 11'h000;
      r_next.fstart = 1'b1;
    end
    r_next.active = (r_next.hcnt < hact) && (r_next.vcnt < vact);
    r_next.vblank = r_next.vcnt >= vact;
    r_next.hs_n = !(r_next.hcnt >= hact + dlc_pkg::HS_FRONT &&
                    r_next.hcnt < hact + dlc_pkg::HS_FRONT + dlc_pkg::HS_WIDTH);
    r_next.vs_n = !(r_next.vcnt >= vact + dlc_pkg::VS_FRONT &&
                    r_next.vcnt < vact + dlc_pkg::VS_FRONT + dlc_pkg::VS_WIDTH);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{hcnt: 11'h000, vcnt: 11'h000, hs_n: 1'b1, vs_n: 1'b1,
                 vblank: 1'b0, active: 1'b0, fstart: 1'b0,
                 ext_hs_d: 1'b1, ext_vs_d: 1'b1};
    end else begin
      r_reg <= r_next;
    end
  end

  assign x      = r_reg.hcnt;
  assign y      = r_reg.vcnt;
  assign active = r_reg.active;
  assign hs_n   = r_reg.hs_n;
  assign vs_n   = r_reg.vs_n;
  assign vblank = r_reg.vblank;
  assign fstart = r_reg.fstart;
endmodule

// >>> core/dlc_compositor.sv
`timescale 1ns/100ps
module dlc_compositor (
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic [11:0] PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [15:0] PIX_BASE,
  input  wire logic [15:0] PIX_OVL1,
  input  wire logic [15:0] PIX_OVL2,
  input  wire logic [15:0] PIX_OVL3,
  input  wire logic [7:0]  CURSOR0_IDX,
  input  wire logic [7:0]  CURSOR1_IDX,
  output logic      [10:0] PIX_X,
  output logic      [10:0] PIX_Y,
  output logic             PIX_ACTIVE,
  output logic             DISP_BANK,
  output logic      [23:0] FETCH_BASE,
  output logic      [7:0]  RED,
  output logic      [7:0]  GREEN,
  output logic      [7:0]  BLUE,
  input  wire logic        HSYNC_N_I,
  output logic             HSYNC_N_O,
  output logic             HSYNC_OE,
  input  wire logic        VSYNC_N_I,
  output logic             VSYNC_N_O,
  output logic             VSYNC_OE,
  input  wire logic        FIELD_PARITY_I,
  output logic             FIELD_PARITY_O,
  output logic             FIELD_PARITY_OE,
  output logic             CSYNC_N,
  output logic             GRAPHICS_VIDEO_SELECT
);
  dlc_pkg::dlc_st_t s_reg;
  dlc_pkg::dlc_st_t s_next;
  logic [10:0]      tg_x;
  logic [10:0]      tg_y;
  logic             tg_active;
  logic             tg_hs_n;
  logic             tg_vs_n;
  logic             tg_vblank;
  logic             tg_fstart;
  logic             ext_mode;
  logic             win_left;
  logic             win_direct;
  logic [5:0][15:0] code;
  logic [5:0][23:0] lay_rgb;
  logic [5:0]       lay_tr;
  logic [5:0]       lay_ab;
  logic [1:0]       cur_hit;

  // Blend one channel by the frame ratio
  function automatic logic [7:0] mix8(input logic [7:0] t, input logic [7:0] l,
                                      input logic [7:0] a);
    logic [15:0] sum;
    sum = 16'({8'h00, t} * {8'h00, a}) + 16'({8'h00, l} * {8'h00, 8'hff - a});
    return sum[15:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timing generator
  dlc_timing u_timing (
    .clk      (REF_CLK),
    .rst_n    (NRST),
    .h_act    (s_reg.h_act),
    .h_tot    (s_reg.h_tot),
    .v_act    (s_reg.v_act),
    .v_tot    (s_reg.v_tot),
    .ext_mode (ext_mode),
    .ext_hs_n (s_reg.hs_s),
    .ext_vs_n (s_reg.vs_s),
    .x        (tg_x),
    .y        (tg_y),
    .active   (tg_active),
    .hs_n     (tg_hs_n),
    .vs_n     (tg_vs_n),
    .vblank   (tg_vblank),
    .fstart   (tg_fstart)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Window selection and per-layer colour lookup
  assign ext_mode   = s_reg.ctrl[dlc_pkg::CTRL_EXT];
  assign win_left   = tg_x < s_reg.split;
  assign win_direct = win_left ? s_reg.ctrl[dlc_pkg::CTRL_DIRL]
                               : s_reg.ctrl[dlc_pkg::CTRL_DIRR];
  assign code = {{8'h00, CURSOR1_IDX}, {8'h00, CURSOR0_IDX},
                 PIX_OVL3, PIX_OVL2, PIX_OVL1, PIX_BASE};

  generate
    for (genvar i = 0; i < 6; i++) begin : g_lay
      logic        drct;
      logic [18:0] ent;
      assign drct = (i < 4) && win_direct;
      assign ent  = s_reg.pal[code[i][7:0]];
      // Palette 6-bit or direct 5-bit channels widened to 8 bits
      assign lay_rgb[i] = drct ?
        {code[i][14:10], code[i][14:12], code[i][9:5], code[i][9:7],
         code[i][4:0], code[i][4:2]} :
        {ent[17:12], ent[17:16], ent[11:6], ent[11:10], ent[5:0], ent[5:4]};
      // Zero cursor code counts as see-through; for layers 0-3 a zero code or zero direct colour only with CTRL_TRANS set
      assign lay_tr[i] = (i >= 4) ? (code[i][7:0] == 8'h00) :
        (s_reg.ctrl[dlc_pkg::CTRL_TRANS] &&
         (drct ? (code[i][14:0] == 15'h0000) : (code[i][7:0] == 8'h00)));
      assign lay_ab[i] = drct ? 1'b1 : ent[dlc_pkg::PAL_ALPHA];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus, pins, composition
  always_comb begin
    logic [23:0] col;
    logic        any;
    logic [10:0] dx;
    logic [10:0] dy;
    logic        known;
    logic [31:0] rd;
    col = 24'h000000;
    any = 1'b0;
    dx = 11'h000;
    dy = 11'h000;
    known = 1'b0;
    rd = 32'h00000000;
    s_next = s_reg;
    cur_hit = 2'b00;

    // Sync pin inputs, two flops each
    s_next.hs_m = HSYNC_N_I;
    s_next.hs_s = s_reg.hs_m;
    s_next.vs_m = VSYNC_N_I;
    s_next.vs_s = s_reg.vs_m;
    s_next.fp_m = FIELD_PARITY_I;
    s_next.fp_s = s_reg.fp_m;

    // Register read mux and decode
    known = 1'b1;
    if (PADDR[11:10] == dlc_pkg::PAL_PAGE) begin
      rd = {13'h0000, s_reg.pal[PADDR[9:2]]};
    end else begin
      unique case (PADDR)
        dlc_pkg::OFF_CTRL:    rd = {18'h00000, s_reg.ctrl};
        dlc_pkg::OFF_ALPHA:   rd = {24'h000000, s_reg.alpha};
        dlc_pkg::OFF_SPLIT:   rd = {21'h000000, s_reg.split};
        dlc_pkg::OFF_HTIM:    rd = {5'h00, s_reg.h_tot, 5'h00, s_reg.h_act};
        dlc_pkg::OFF_VTIM:    rd = {5'h00, s_reg.v_tot, 5'h00, s_reg.v_act};
        dlc_pkg::OFF_START_L: rd = {8'h00, s_reg.start_l};
        dlc_pkg::OFF_START_R: rd = {8'h00, s_reg.start_r};
        dlc_pkg::OFF_CUR0:    rd = {5'h00, s_reg.cur[0][21:11], 5'h00, s_reg.cur[0][10:0]};
        dlc_pkg::OFF_CUR1:    rd = {5'h00, s_reg.cur[1][21:11], 5'h00, s_reg.cur[1][10:0]};
        dlc_pkg::OFF_FLIP:    rd = {31'h00000000, s_reg.flip_pend};
        dlc_pkg::OFF_STATUS:  rd = {5'h00, tg_y, 12'h000, s_reg.field, tg_vblank,
                                    s_reg.bank, s_reg.flip_pend};
        default: begin
          known = 1'b0;
          rd = 32'h00000000;
        end
      endcase
    end
    // Read data and error latched in the setup cycle
    if (PSEL && !PENABLE) begin
      s_next.prdata = PWRITE ? 32'h00000000 : rd;
      s_next.slverr = !known;
    end

    // Frame events: latch ratio, apply pending flip
    if (tg_fstart) begin
      s_next.alpha_frame = s_reg.alpha;
      if (s_reg.flip_pend && s_reg.ctrl[dlc_pkg::CTRL_DBUF]) begin
        s_next.bank = !s_reg.bank;
      end
      s_next.flip_pend = 1'b0;
      // Field id: from pin in external mode, else toggle when interlaced
      s_next.field = ext_mode ? s_reg.fp_s :
                     (s_reg.ctrl[dlc_pkg::CTRL_INTL] ? !s_reg.field : 1'b0);
    end
    if (!s_reg.ctrl[dlc_pkg::CTRL_DBUF]) begin
      s_next.bank = 1'b0;
    end

    // Register writes take effect at the access edge
    if (PSEL && PENABLE && PWRITE && known) begin
      if (PADDR[11:10] == dlc_pkg::PAL_PAGE) begin
        s_next.pal[PADDR[9:2]] = PWDATA[18:0];
      end else begin
        unique case (PADDR)
          dlc_pkg::OFF_CTRL:    s_next.ctrl = PWDATA[13:0];
          dlc_pkg::OFF_ALPHA:   s_next.alpha = PWDATA[7:0];
          dlc_pkg::OFF_SPLIT:   s_next.split = PWDATA[10:0];
          dlc_pkg::OFF_HTIM: begin
            s_next.h_act = PWDATA[10:0];
            s_next.h_tot = PWDATA[26:16];
          end
          dlc_pkg::OFF_VTIM: begin
            s_next.v_act = PWDATA[10:0];
            s_next.v_tot = PWDATA[26:16];
          end
          dlc_pkg::OFF_START_L: s_next.start_l = PWDATA[23:0];
          dlc_pkg::OFF_START_R: s_next.start_r = PWDATA[23:0];
          dlc_pkg::OFF_CUR0:    s_next.cur[0] = {PWDATA[26:16], PWDATA[10:0]};
          dlc_pkg::OFF_CUR1:    s_next.cur[1] = {PWDATA[26:16], PWDATA[10:0]};
          dlc_pkg::OFF_FLIP: begin
            if (PWDATA[0]) begin
              s_next.flip_pend = 1'b1;
            end
          end
          default: begin
            s_next.flip_pend = s_next.flip_pend;
          end
        endcase
      end
    end

    // Base window, then overlays in order
    col = lay_tr[0] ? 24'h000000 : lay_rgb[0];
    any = !lay_tr[0];
    for (int k = 1; k < 4; k++) begin
      if (s_reg.ctrl[dlc_pkg::CTRL_LAYEN + k - 1] && !lay_tr[k]) begin
        any = 1'b1;
        // Transparency already decided above; blend only mixes colours
        if (s_reg.ctrl[dlc_pkg::CTRL_BLEND + k - 1] && lay_ab[k]) begin
          col = {mix8(lay_rgb[k][23:16], col[23:16], s_reg.alpha_frame),
                 mix8(lay_rgb[k][15:8], col[15:8], s_reg.alpha_frame),
                 mix8(lay_rgb[k][7:0], col[7:0], s_reg.alpha_frame)};
        end else begin
          col = lay_rgb[k];
        end
      end
    end
    // Cursors on top, cursor 0 above cursor 1
    for (int c = 1; c >= 0; c--) begin
      dx = tg_x - s_reg.cur[c][10:0];
      dy = tg_y - s_reg.cur[c][21:11];
      cur_hit[c] = s_reg.ctrl[dlc_pkg::CTRL_CUREN + c] && dx < dlc_pkg::CUR_SIZE &&
                   dy < dlc_pkg::CUR_SIZE;
      if (cur_hit[c] && !lay_tr[4 + c]) begin
        col = lay_rgb[4 + c];
        any = 1'b1;
      end
    end

    // Output stage, one cycle behind the pixel position
    s_next.rgb = tg_active ? col : 24'h000000;
    s_next.gv = !(ext_mode && (!tg_active || !any));
    s_next.hs_d = tg_hs_n;
    s_next.vs_d = tg_vs_n;
    s_next.fetch_base = win_left ? s_reg.start_l : s_reg.start_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      s_reg <= '0;
      s_reg.ctrl <= dlc_pkg::CTRL_RST;
      s_reg.alpha <= dlc_pkg::ALPHA_RST;
      s_reg.alpha_frame <= dlc_pkg::ALPHA_RST;
      s_reg.split <= dlc_pkg::SPLIT_RST;
      s_reg.h_act <= dlc_pkg::HACT_RST;
      s_reg.h_tot <= dlc_pkg::HTOT_RST;
      s_reg.v_act <= dlc_pkg::VACT_RST;
      s_reg.v_tot <= dlc_pkg::VTOT_RST;
      s_reg.gv <= 1'b1;
      s_reg.hs_d <= 1'b1;
      s_reg.vs_d <= 1'b1;
      s_reg.hs_m <= 1'b1;
      s_reg.hs_s <= 1'b1;
      s_reg.vs_m <= 1'b1;
      s_reg.vs_s <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA          = s_reg.prdata;
  assign PREADY          = 1'b1;
  assign PSLVERR         = s_reg.slverr && PSEL && PENABLE;
  assign PIX_X           = tg_x;
  assign PIX_Y           = tg_y;
  assign PIX_ACTIVE      = tg_active;
  assign DISP_BANK       = s_reg.bank;
  assign FETCH_BASE      = s_reg.fetch_base;
  assign RED             = s_reg.rgb[23:16];
  assign GREEN           = s_reg.rgb[15:8];
  assign BLUE            = s_reg.rgb[7:0];
  // Sync pins drive only outside external mode
  assign HSYNC_N_O       = s_reg.hs_d;
  assign HSYNC_OE        = !ext_mode;
  assign VSYNC_N_O       = s_reg.vs_d;
  assign VSYNC_OE        = !ext_mode;
  assign FIELD_PARITY_O  = s_reg.field;
  assign FIELD_PARITY_OE = !ext_mode;
  assign CSYNC_N         = s_reg.hs_d && s_reg.vs_d;
  assign GRAPHICS_VIDEO_SELECT = s_reg.gv;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  pal_write_a: assert property (PSEL && PENABLE && PWRITE && PADDR[11:10] == 2'h1
    |=> s_reg.pal[$past(PADDR[9:2])] == $past(PWDATA[18:0]))
    else $error("palette write lost");
  base_lookup_a: assert property (tg_active && s_reg.ctrl[13:6] == 8'h00 && !lay_tr[0]
    |=> {RED, GREEN, BLUE} == $past(lay_rgb[0]))
    else $error("base pixel colour wrong");
  direct_expand_a: assert property (win_direct
    |-> lay_rgb[0][23:16] == {PIX_BASE[14:10], PIX_BASE[14:12]})
    else $error("direct red expansion wrong");
  ratio_hold_a: assert property (!tg_fstart |=> $stable(s_reg.alpha_frame))
    else $error("blend ratio changed mid frame");
  zero_transp_a: assert property (s_reg.ctrl[2] && !win_direct && PIX_OVL1[7:0] == 8'h00
    |-> lay_tr[1])
    else $error("zero code not transparent");
  cursor_top_a: assert property (tg_active && cur_hit[0] && CURSOR0_IDX != 8'h00
    |=> {RED, GREEN, BLUE} == $past(lay_rgb[4]))
    else $error("cursor not on top");
  sync_dir_a: assert property (HSYNC_OE == !s_reg.ctrl[1] && VSYNC_OE == HSYNC_OE)
    else $error("sync pin direction wrong");
  gv_internal_a: assert property (!ext_mode |=> GRAPHICS_VIDEO_SELECT)
    else $error("video selected outside external mode");
  flip_frame_a: assert property (!tg_fstart && s_reg.ctrl[0] |=> $stable(DISP_BANK))
    else $error("bank flipped mid frame");
  blank_black_a: assert property (!tg_active |=> {RED, GREEN, BLUE} == 24'h000000)
    else $error("colour outside active area");

  flip_c: cover property (s_reg.flip_pend ##1 $changed(DISP_BANK));
  blend_c: cover property (tg_active && s_reg.ctrl[9] && s_reg.ctrl[6] && !lay_tr[1]);
  cursor_c: cover property (tg_active && cur_hit[1] && CURSOR1_IDX != 8'h00);
  video_c: cover property (ext_mode ##1 !GRAPHICS_VIDEO_SELECT);
endmodule

// >>> tb/dlc_video_src.sv
`timescale 1ns/100ps
module dlc_video_src (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic drive_en,
  output logic      hs_n,
  output logic      vs_n,
  output logic      fp
);
  logic [9:0] cnt_reg;
  // Line timer of the far side, idle while the device drives its own sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 10'h000;
    end else begin
      cnt_reg <= (!drive_en || cnt_reg == 10'h31f) ? 10'h000 : cnt_reg + 10'h001;
    end
  end
  // Released sync pins rest at the pull-up level
  assign hs_n = !(drive_en && cnt_reg < 10'h060);
  assign vs_n = 1'b1;
  assign fp   = 1'b0;
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        REF_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [15:0] pix_b = 16'h0000;
  logic [15:0] pix_o = 16'h0000;
  logic [7:0]  cur0 = 8'h00;
  logic [31:0] PRDATA, rd;
  logic [10:0] PIX_X, PIX_Y;
  logic [23:0] fb;
  logic [7:0]  RED, GREEN, BLUE;
  logic        PREADY, PSLVERR, PIX_ACTIVE, er, gv, hs_o, hs_oe, vs_o, vs_oe;
  logic        fp_o, fp_oe, m_hs, m_vs, m_fp, bank;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;
  typedef struct packed {logic [11:0] a; logic w; logic [31:0] d, x; logic e;} dlc_tb_reg_t;
  typedef struct packed {logic [31:0] c; logic [15:0] b, o; logic [7:0] k;
                         logic [2:0] v; logic g;} dlc_tb_pix_t;
  // Register rows: address, write, data, expected read, expected error
  dlc_tb_reg_t regs [11] = '{'{'h004, 0, 0, 'h80, 0}, '{'h008, 0, 0, 'h7ff, 0},
    '{'h00c, 0, 0, 'h0320_0280, 0}, '{'h010, 0, 0, 'h020d_01e0, 0},
    '{'h004, 1, 'hffff_ffff, 0, 0}, '{'h004, 0, 0, 'hff, 0}, '{'h414, 1, 'h3f000, 0, 0},
    '{'h414, 0, 0, 'h3f000, 0}, '{'h418, 1, 'h3f, 0, 0}, '{'h41c, 1, 'hfc0, 0, 0},
    '{'h300, 0, 0, 0, 1}};
  // Pixel rows: control, base, overlays 1-3, cursor, colour present r/g/b, select
  dlc_tb_pix_t pix [10] = '{'{'h0000, 5, 0, 0, 3'b100, 1}, '{'h0044, 5, 0, 0, 3'b100, 1},
    '{'h0044, 5, 6, 0, 3'b001, 1}, '{'h1044, 5, 6, 7, 3'b010, 1},
    '{'h1044, 5, 6, 0, 3'b001, 1}, '{'h0008, 'h7c00, 0, 0, 3'b100, 1},
    '{'h000c, 0, 0, 0, 3'b000, 1}, '{'h2044, 5, 6, 7, 3'b010, 1},
    '{'h024c, 'h7c00, 'h001f, 0, 3'b101, 1}, '{'h0184, 5, 6, 0, 3'b001, 1}};

  dlc_compositor dut_u (
    .REF_CLK(REF_CLK), .NRST(NRST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PIX_BASE(pix_b), .PIX_OVL1(pix_o), .PIX_OVL2(pix_o), .PIX_OVL3(pix_o),
    .CURSOR0_IDX(cur0), .CURSOR1_IDX(cur0), .PIX_X(PIX_X), .PIX_Y(PIX_Y),
    .PIX_ACTIVE(PIX_ACTIVE), .DISP_BANK(bank), .FETCH_BASE(fb), .RED(RED), .GREEN(GREEN),
    .BLUE(BLUE), .HSYNC_N_I(hs_oe ? hs_o : m_hs), .HSYNC_N_O(hs_o), .HSYNC_OE(hs_oe),
    .VSYNC_N_I(vs_oe ? vs_o : m_vs), .VSYNC_N_O(vs_o), .VSYNC_OE(vs_oe),
    .FIELD_PARITY_I(fp_oe ? fp_o : m_fp), .FIELD_PARITY_O(fp_o), .FIELD_PARITY_OE(fp_oe),
    .CSYNC_N(), .GRAPHICS_VIDEO_SELECT(gv));
  dlc_video_src src_u (.clk(REF_CLK), .rst_n(NRST), .drive_en(!hs_oe), .hs_n(m_hs),
    .vs_n(m_vs), .fp(m_fp));

  always #10 REF_CLK = ~REF_CLK;

  // Hang guard
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; answer taken at the edge where pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Wait for an active pixel (any, or line y at column 20), then settle
  task automatic at_pixel(input logic [10:0] y, input logic any);
    int k;
    k = 0;
    do begin
      @(posedge REF_CLK);
      k++;
    end while (!(PIX_ACTIVE === 1'b1 && (any || (PIX_Y === y && PIX_X === 11'h014)))
               && k < 3000);
    @(negedge REF_CLK);
    check({31'h0, k < 3000}, 32'h1);
  endtask

  initial begin
    #100;
    check({22'h0, hs_oe, gv, RED}, {22'h0, 1'b1, 1'b1, 8'h00});
    repeat (16) @(posedge REF_CLK);
    NRST <= 1'b1;
    foreach (regs[i]) begin
      apb(regs[i].a, regs[i].w, regs[i].d);
      if (!regs[i].w) check(rd, regs[i].x);
      check({31'h0, er}, {31'h0, regs[i].e});
    end
    apb(12'h01c, 1'b1, 32'h0);
    // Internal line sync pulse width
    n = 0;
    while (hs_o !== 1'b1 && n < 2000) begin @(posedge REF_CLK); n++; end
    while (hs_o !== 1'b0 && n < 2000) begin @(posedge REF_CLK); n++; end
    n = 0;
    while (hs_o === 1'b0 && n < 200) begin @(posedge REF_CLK); n++; end
    check(n, 32'd96);
    foreach (pix[i]) begin
      apb(12'h000, 1'b1, pix[i].c);
      pix_b <= pix[i].b;
      pix_o <= pix[i].o;
      cur0 <= pix[i].k;
      at_pixel(PIX_Y + 11'h002, 1'b0);
      check({29'h0, RED != 0, GREEN != 0, BLUE != 0}, {29'h0, pix[i].v});
      check({31'h0, gv}, {31'h0, pix[i].g});
    end
    // External sync with a see-through base: video must be selected
    apb(12'h000, 1'b1, 32'h0000_0006);
    pix_b <= 16'h0000;
    @(negedge REF_CLK);
    check({29'h0, hs_oe, vs_oe, fp_oe}, 32'h0);
    at_pixel(11'h000, 1'b1);
    check({31'h0, gv}, 32'h0);
    // Line counter restarts three edges after the outside sync falls
    while (m_hs !== 1'b1) @(posedge REF_CLK);
    while (m_hs !== 1'b0) @(posedge REF_CLK);
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    check({21'h0, PIX_X}, 32'h0);
    // Short frames, double buffer on, flip asked for inside vertical blanking
    apb(12'h00c, 1'b1, 32'h0020_0280);
    apb(12'h010, 1'b1, 32'h00f0_00ea);
    apb(12'h000, 1'b1, 32'h0000_0001);
    while (vs_o !== 1'b0) @(posedge REF_CLK);
    apb(12'h024, 1'b1, 32'h0000_0001);
    check({31'h0, bank}, 32'h0);
    n = 0;
    while (bank !== 1'b1 && n < 300) begin @(posedge REF_CLK); n++; end
    apb(12'h028, 1'b0, 32'h0);
    check({28'h0, rd[3:0]}, 32'h2);
    // Fetch start follows the window under the scan
    apb(12'h014, 1'b1, 32'h0012_3456);
    apb(12'h018, 1'b1, 32'h0065_4321);
    @(negedge REF_CLK);
    check({8'h0, fb}, 32'h0012_3456);
    apb(12'h008, 1'b1, 32'h0);
    @(posedge REF_CLK);
    @(negedge REF_CLK);
    check({8'h0, fb}, 32'h0065_4321);
    end_of_test();
  end
endmodule
